// ==== core/fpwdm_top.v ====
// Power-down, wake-up and boot drive mapping logic of the floppy controller.
//
// Summary of operation
// R01: Any reset initializes registers, then after a delay raises an interrupt.
// R02: In auto powerdown the main status register reads 80H.
// R03: Powerdown and idle bits appear in status B or the input register by mode.
// R04: Idle pin is high while idle; the idle mask drives it low.
// R05: Waking from rate-register powerdown resets the device and drops status.
// R06: In rate-register powerdown the transfer request flag stays set.
// R07: Software or hardware reset ends rate-register powerdown.
// R08: A status read in auto powerdown starts wake-up.
// R09: While waking with no byte held the status reads 80H; one command byte is accepted.
// R10: Without a command, wake, run the minimum on timer, then sleep again.
// R11: A byte taken while waking is held, the request flag drops, then executes.
// R12: A byte written without a status read also wakes and is held.
// R13: Writing a motor enable active wakes with the request flag kept high.
// R14: Software reads status and sees the request flag before each command.
// R15: Software restarts the oscillator well before waking the part.
// R16: The powerdown pin powers down the oscillator.
// R17: Drive select bits decode one-hot; motor enables come from the register.
// R18: Virtual selects and motors route to pins by the boot map bits.
// R19: Boot map 00 maps drives 0, 1, 2 straight.
// R20: Boot map 01 swaps drives 0 and 1.
// R21: Boot map 10 swaps drives 0 and 2; 11 is reserved.
// R22: With a non-default map, tape matching also uses virtual numbers.
// R23: Reset clears the digital output register to 00H.
// R24: Minimum on timer length is a parameter; boot map 11 acts as 00.
`timescale 1ns/1ps

`include "fpwdm_regs.vh"

module fpwdm_top #(
  parameter CNT_W         = 16,
  parameter WAKE_CYCLES   = `FPWDM_WAKE_CYCLES,
  parameter MIN_ON_CYCLES = `FPWDM_MIN_ON_CYCLES,
  parameter INIT_CYCLES   = `FPWDM_INIT_CYCLES
) (
  clock,
  sys_rst,
  soft_reset_req,
  msr_read_stb,
  fifo_write_stb,
  fifo_wdata,
  dor_write_stb,
  dor_wdata,
  tdr_write_stb,
  tdr_wdata,
  dsr_powerdown_req,
  auto_pd_en,
  core_idle,
  core_msr,
  enhanced_mode,
  idle_pin_mask,
  osc_powerdown_sw,
  powerdown_pin,
  main_status_reg,
  digital_output_reg,
  tape_drive_reg,
  cmd_valid,
  cmd_byte,
  core_init,
  int_req,
  part_awake,
  status_reg_b_pd_idle,
  dir_pd_idle,
  idle_pin,
  osc_powerdown,
  phys_drive_sel_pin,
  phys_motor_on_pin,
  tape_mode
);
  input  wire       clock;
  input  wire       sys_rst;
  input  wire       soft_reset_req;
  input  wire       msr_read_stb;
  input  wire       fifo_write_stb;
  input  wire [7:0] fifo_wdata;
  input  wire       dor_write_stb;
  input  wire [7:0] dor_wdata;
  input  wire       tdr_write_stb;
  input  wire [7:0] tdr_wdata;
  input  wire       dsr_powerdown_req;
  input  wire       auto_pd_en;
  input  wire       core_idle;
  input  wire [7:0] core_msr;
  input  wire       enhanced_mode;
  input  wire       idle_pin_mask;
  input  wire       osc_powerdown_sw;
  input  wire       powerdown_pin;
  output reg  [7:0] main_status_reg;
  output reg  [7:0] digital_output_reg;
  output reg  [7:0] tape_drive_reg;
  output reg        cmd_valid;
  output reg  [7:0] cmd_byte;
  output reg        core_init;
  output reg        int_req;
  output reg        part_awake;
  output reg  [1:0] status_reg_b_pd_idle;
  output reg  [1:0] dir_pd_idle;
  output reg        idle_pin;
  output reg        osc_powerdown;
  output reg  [3:0] phys_drive_sel_pin;
  output reg  [3:0] phys_motor_on_pin;
  output reg        tape_mode;

  // Power states of the part.
  localparam [2:0] ST_INIT    = 3'h0;
  localparam [2:0] ST_AWAKE   = 3'h1;
  localparam [2:0] ST_AUTO_PD = 3'h2;
  localparam [2:0] ST_WAKING  = 3'h3;
  localparam [2:0] ST_MIN_ON  = 3'h4;
  localparam [2:0] ST_DSR_PD  = 3'h5;

  localparam [CNT_W-1:0] WAKE_LOAD = WAKE_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] MIN_LOAD  = MIN_ON_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] INIT_LOAD = INIT_CYCLES[CNT_W-1:0];

  reg  [2:0]       state_r;
  reg  [2:0]       state_nxt;
  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] cnt_nxt;
  reg              held_r;
  reg              held_nxt;
  reg  [7:0]       hold_byte_r;
  reg  [7:0]       hold_byte_nxt;
  reg              deliver_nxt;
  reg  [7:0]       deliver_byte_nxt;
  reg              init_nxt;
  reg              int_nxt;
  reg  [7:0]       msr_nxt;
  reg              pd_s1_r;
  reg              pd_s2_r;
  reg              pd_s3_r;
  reg              pd_lvl_r;
  wire             motor_req;
  wire             motors_off;
  wire             sleeping;
  wire [3:0]       map_sel;
  wire [3:0]       map_motor;
  wire [1:0]       tape_sel;

  assign motor_req  = dor_write_stb &&
                      (dor_wdata[`FPWDM_DOR_MOTOR_MSB:`FPWDM_DOR_MOTOR_LSB] != 4'h0);
  assign motors_off =
    (digital_output_reg[`FPWDM_DOR_MOTOR_MSB:`FPWDM_DOR_MOTOR_LSB] == 4'h0);
  assign sleeping   = (state_r == ST_AUTO_PD) || (state_r == ST_DSR_PD);
  assign tape_sel   = tape_drive_reg[`FPWDM_TDR_TAPE_MSB:`FPWDM_TDR_TAPE_LSB];

  // Next power state, wake counter, held command byte and status value.
  always @* begin
    state_nxt        = state_r;
    cnt_nxt          = cnt_r;
    held_nxt         = held_r;
    hold_byte_nxt    = hold_byte_r;
    deliver_nxt      = 1'b0;
    deliver_byte_nxt = fifo_wdata;
    init_nxt         = 1'b0;
    int_nxt          = 1'b0;
    msr_nxt          = core_msr;
    case (state_r)
      ST_INIT: begin
        // Registers were initialized at entry; the interrupt follows the delay.
        msr_nxt = `FPWDM_MSR_BLOCKED;
        if (cnt_r == {CNT_W{1'b0}}) begin
          int_nxt   = 1'b1; // [R01]
          state_nxt = ST_AWAKE;
        end else begin
          cnt_nxt = cnt_r - 1'b1; // [R01]
        end
      end
      ST_AWAKE: begin
        if (fifo_write_stb) begin
          deliver_nxt = 1'b1;
        end
        if (dsr_powerdown_req) begin
          state_nxt = ST_DSR_PD;
          msr_nxt   = `FPWDM_MSR_READY;
        end else if (auto_pd_en && core_idle && motors_off && !fifo_write_stb) begin
          state_nxt = ST_AUTO_PD;
          msr_nxt   = `FPWDM_MSR_READY;
        end
      end
      ST_DSR_PD: begin
        // Only a reset leaves this state, and the request flag stays set.
        msr_nxt = `FPWDM_MSR_READY; // [R06]
      end
      ST_AUTO_PD: begin
        msr_nxt = `FPWDM_MSR_READY; // [R02]
        if (fifo_write_stb) begin
          // A byte without a prior status read still wakes the part.
          held_nxt      = 1'b1; // [R12]
          hold_byte_nxt = fifo_wdata; // [R12]
          msr_nxt       = `FPWDM_MSR_BLOCKED; // [R12]
          state_nxt     = ST_WAKING;
          cnt_nxt       = WAKE_LOAD;
        end else if (msr_read_stb || motor_req) begin
          state_nxt = ST_WAKING; // [R08] [R13]
          cnt_nxt   = WAKE_LOAD;
        end
      end
      ST_WAKING: begin
        msr_nxt = held_r ? `FPWDM_MSR_BLOCKED : `FPWDM_MSR_READY; // [R09] [R13]
        if (fifo_write_stb && !held_r) begin
          held_nxt      = 1'b1; // [R11]
          hold_byte_nxt = fifo_wdata; // [R09] [R11]
          msr_nxt       = `FPWDM_MSR_BLOCKED; // [R11]
        end
        if (cnt_r == {CNT_W{1'b0}}) begin
          if (held_r) begin
            // Fully awake: hand the remembered byte to the core.
            deliver_nxt      = 1'b1; // [R11] [R12]
            deliver_byte_nxt = hold_byte_r;
            held_nxt         = 1'b0;
            state_nxt        = ST_AWAKE;
          end else if (fifo_write_stb) begin
            deliver_nxt = 1'b1;
            state_nxt   = ST_AWAKE;
          end else begin
            state_nxt = ST_MIN_ON; // [R10]
            cnt_nxt   = MIN_LOAD; // [R10] [R24]
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_MIN_ON: begin
        if (fifo_write_stb || !core_idle || dsr_powerdown_req) begin
          deliver_nxt = fifo_write_stb;
          state_nxt   = dsr_powerdown_req ? ST_DSR_PD : ST_AWAKE;
        end else if (cnt_r == {CNT_W{1'b0}}) begin
          // Timer ran out with no command: sleep again if still allowed.
          if (auto_pd_en && motors_off) begin
            state_nxt = ST_AUTO_PD; // [R10]
            msr_nxt   = `FPWDM_MSR_READY;
          end else begin
            state_nxt = ST_AWAKE;
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1; // [R10]
        end
      end
      default: begin
        state_nxt = ST_INIT;
        cnt_nxt   = INIT_LOAD;
      end
    endcase
    // A software reset restarts the part from any state, dropping status.
    if (soft_reset_req) begin
      state_nxt = ST_INIT; // [R05] [R07]
      cnt_nxt   = INIT_LOAD;
      held_nxt  = 1'b0; // [R05]
      init_nxt  = 1'b1; // [R01]
      msr_nxt   = `FPWDM_MSR_BLOCKED;
    end
  end

  // Power state registers; a hardware reset also enters initialization.
  always @(posedge clock) begin
    if (sys_rst) begin
      state_r         <= ST_INIT; // [R07]
      cnt_r           <= INIT_LOAD; // [R01]
      held_r          <= 1'b0; // [R05]
      hold_byte_r     <= 8'h00;
      main_status_reg <= `FPWDM_MSR_BLOCKED;
      cmd_valid       <= 1'b0;
      cmd_byte        <= 8'h00;
      core_init       <= 1'b1; // [R01]
      int_req         <= 1'b0;
      part_awake      <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      cnt_r           <= cnt_nxt;
      held_r          <= held_nxt;
      hold_byte_r     <= hold_byte_nxt;
      main_status_reg <= msr_nxt;
      cmd_valid       <= deliver_nxt;
      cmd_byte        <= deliver_nxt ? deliver_byte_nxt : cmd_byte;
      core_init       <= init_nxt;
      int_req         <= int_nxt;
      part_awake      <= (state_nxt != ST_AUTO_PD) && (state_nxt != ST_DSR_PD);
    end
  end

  // Output and tape registers; a soft reset clears them as well.
  always @(posedge clock) begin
    if (sys_rst || soft_reset_req) begin
      digital_output_reg <= `FPWDM_DOR_RESET; // [R23]
      tape_drive_reg     <= `FPWDM_TDR_RESET;
    end else begin
      if (dor_write_stb && state_r != ST_DSR_PD) begin
        digital_output_reg <= dor_wdata; // [R13]
      end
      if (tdr_write_stb && state_r != ST_DSR_PD) begin
        tape_drive_reg <= tdr_wdata;
      end
    end
  end

  // Powerdown pin passes three flops; a change counts once the last two agree.
  always @(posedge clock) begin
    if (sys_rst) begin
      pd_s1_r  <= 1'b0;
      pd_s2_r  <= 1'b0;
      pd_s3_r  <= 1'b0;
      pd_lvl_r <= 1'b0;
    end else begin
      pd_s1_r <= powerdown_pin;
      pd_s2_r <= pd_s1_r;
      pd_s3_r <= pd_s2_r;
      if (pd_s2_r == pd_s3_r) begin
        pd_lvl_r <= pd_s3_r;
      end
    end
  end

  // Oscillator stop, idle pin and the two status bit copies.
  always @(posedge clock) begin
    if (sys_rst) begin
      osc_powerdown        <= 1'b0;
      idle_pin             <= 1'b0;
      status_reg_b_pd_idle <= 2'h0;
      dir_pd_idle          <= 2'h0;
    end else begin
      osc_powerdown <= pd_lvl_r | osc_powerdown_sw; // [R16]
      idle_pin      <= (sleeping || core_idle) && !idle_pin_mask; // [R04]
      // Bit 1 is powerdown, bit 0 is idle; the unused copy reads zero.
      if (enhanced_mode) begin
        status_reg_b_pd_idle <= {sleeping, sleeping || core_idle}; // [R03]
        dir_pd_idle          <= 2'h0;
      end else begin
        status_reg_b_pd_idle <= 2'h0;
        dir_pd_idle          <= {sleeping, sleeping || core_idle}; // [R03]
      end
    end
  end

  // Virtual drive decode and boot remapping.
  fpwdm_drive_map u_map (
    .drive_select_field (digital_output_reg[`FPWDM_DOR_DSEL_MSB:`FPWDM_DOR_DSEL_LSB]),
    .virtual_motor_on   (digital_output_reg[`FPWDM_DOR_MOTOR_MSB:`FPWDM_DOR_MOTOR_LSB]),
    .boot_drive_map_sel (tape_drive_reg[`FPWDM_TDR_BOOT_MSB:`FPWDM_TDR_BOOT_LSB]),
    .phys_drive_sel     (map_sel),
    .phys_motor_on      (map_motor)
  );

  // Physical pins and tape match, registered so every output is a flop.
  always @(posedge clock) begin
    if (sys_rst) begin
      phys_drive_sel_pin <= 4'h0;
      phys_motor_on_pin  <= 4'h0;
      tape_mode          <= 1'b0;
    end else begin
      phys_drive_sel_pin <= map_sel; // [R18]
      phys_motor_on_pin  <= map_motor; // [R17] [R18]
      // Tape choice names a virtual drive, so it follows the remap.
      tape_mode <= (tape_sel != 2'h0) &&
                   (digital_output_reg[`FPWDM_DOR_DSEL_MSB:`FPWDM_DOR_DSEL_LSB]
                    == tape_sel); // [R22]
    end
  end

endmodule // fpwdm_top

// ==== core/fpwdm_regs.vh ====
// Constants for the floppy controller power, wake and drive-map block.
`ifndef FPWDM_REGS_VH
`define FPWDM_REGS_VH

// Digital output register reset value and fields.
`define FPWDM_DOR_RESET     8'h00
`define FPWDM_DOR_DSEL_LSB  0
`define FPWDM_DOR_DSEL_MSB  1
`define FPWDM_DOR_MOTOR_LSB 4
`define FPWDM_DOR_MOTOR_MSB 7

// Tape drive register reset value and fields.
`define FPWDM_TDR_RESET     8'h00
`define FPWDM_TDR_TAPE_LSB  0
`define FPWDM_TDR_TAPE_MSB  1
`define FPWDM_TDR_BOOT_LSB  2
`define FPWDM_TDR_BOOT_MSB  3

// Main status register values shown while the core is asleep.
`define FPWDM_MSR_READY     8'h80
`define FPWDM_MSR_BLOCKED   8'h00

// Boot drive map selections.
`define FPWDM_BOOT_STRAIGHT 2'h0
`define FPWDM_BOOT_SWAP01   2'h1
`define FPWDM_BOOT_SWAP02   2'h2

// Default timing counts in clock cycles.
`define FPWDM_WAKE_CYCLES   64
`define FPWDM_MIN_ON_CYCLES 2000
`define FPWDM_INIT_CYCLES   200

`endif

// ==== core/fpwdm_drive_map.v ====
// Drive select decode and boot drive remapping onto physical pins.
`timescale 1ns/1ps

`include "fpwdm_regs.vh"

module fpwdm_drive_map (
  drive_select_field,
  virtual_motor_on,
  boot_drive_map_sel,
  phys_drive_sel,
  phys_motor_on
);
  input  wire [1:0] drive_select_field;
  input  wire [3:0] virtual_motor_on;
  input  wire [1:0] boot_drive_map_sel;
  output wire [3:0] phys_drive_sel;
  output wire [3:0] phys_motor_on;

  wire [3:0] virtual_drive_sel;

  // The two select bits decode to one-hot virtual selects.
  assign virtual_drive_sel = 4'h1 << drive_select_field; // [R17]

  // Each swap is its own inverse, so a physical pin reads the virtual
  // drive whose index is its own index passed through the same swap.
  // The pin index arrives as an integer, since a loop index cannot be part-selected.
  function [1:0] fpwdm_swap;
    input integer idx;
    input [1:0]   sel;
    begin
      fpwdm_swap = idx[1:0];
      case (sel)
        `FPWDM_BOOT_SWAP01: begin
          if (idx == 0) fpwdm_swap = 2'h1; // [R20]
          if (idx == 1) fpwdm_swap = 2'h0; // [R20]
        end
        `FPWDM_BOOT_SWAP02: begin
          if (idx == 0) fpwdm_swap = 2'h2; // [R21]
          if (idx == 2) fpwdm_swap = 2'h0; // [R21]
        end
        default: fpwdm_swap = idx[1:0]; // Straight and reserved. [R19] [R24]
      endcase
    end
  endfunction

  // Route every virtual select and motor enable to its physical pin.
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_pin
      assign phys_drive_sel[p] =
        virtual_drive_sel[fpwdm_swap(p, boot_drive_map_sel)]; // [R18]
      assign phys_motor_on[p] =
        virtual_motor_on[fpwdm_swap(p, boot_drive_map_sel)]; // [R18]
    end
  endgenerate

endmodule // fpwdm_drive_map

// ==== tb/fpwdm_chk_assertions.sv ====
// Concurrent checks on the ports of the power, wake and drive-map block.
`timescale 1ns/1ps

module fpwdm_chk (
  input wire       clock,
  input wire       sys_rst,
  input wire       soft_reset_req,
  input wire       fifo_write_stb,
  input wire       dsr_powerdown_req,
  input wire       idle_pin_mask,
  input wire       powerdown_pin,
  input wire       part_awake,
  input wire       core_init,
  input wire       idle_pin,
  input wire       osc_powerdown,
  input wire [7:0] main_status_reg,
  input wire [7:0] digital_output_reg,
  input wire [7:0] tape_drive_reg,
  input wire [3:0] phys_drive_sel_pin,
  input wire [3:0] phys_motor_on_pin
);
  // Works out the physical pins from the output and tape registers.
  function [3:0] exp_pins(input [7:0] out_reg, input [7:0] tape_reg, input motor);
    reg [3:0] v;
    begin
      v = motor ? out_reg[7:4] : 4'h1 << out_reg[1:0];
      exp_pins = v;
      if (tape_reg[3:2] == 2'h1) begin
        exp_pins[0] = v[1];
        exp_pins[1] = v[0];
      end else if (tape_reg[3:2] == 2'h2) begin
        exp_pins[0] = v[2];
        exp_pins[2] = v[0];
      end
    end
  endfunction

  // Reset behaviour of registers and initialization.
  a_reset_dor_clear: assert property (@(posedge clock)
    sys_rst |=> digital_output_reg == 8'h00 && tape_drive_reg == 8'h00)
    else $error("output register not cleared by reset");
  a_reset_init: assert property (@(posedge clock) sys_rst |=> core_init)
    else $error("no initialization during reset");
  a_soft_init: assert property (@(posedge clock) disable iff (sys_rst)
    soft_reset_req |=> core_init)
    else $error("no initialization after software reset");

  // Idle and oscillator outputs.
  a_idle_mask: assert property (@(posedge clock) disable iff (sys_rst)
    idle_pin_mask |=> !idle_pin)
    else $error("idle pin high while masked");
  a_osc_pin: assert property (@(posedge clock) disable iff (sys_rst)
    powerdown_pin [*5] |=> osc_powerdown)
    else $error("oscillator not stopped by powerdown pin");

  // Status register while asleep.
  a_cmd_block: assert property (@(posedge clock)
    disable iff (sys_rst || soft_reset_req)
    !part_awake && main_status_reg == 8'h80 && fifo_write_stb
      |=> ##[0:1] main_status_reg == 8'h00)
    else $error("request flag kept after byte taken asleep");
  a_dsr_ready: assert property (@(posedge clock)
    disable iff (sys_rst || soft_reset_req)
    dsr_powerdown_req |=> ##[0:1] main_status_reg[7])
    else $error("request flag not set in rate powerdown");

  // Drive select and motor remapping, one cycle behind the registers.
  a_drive_map: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) && !$past(soft_reset_req) |-> phys_drive_sel_pin ==
      exp_pins($past(digital_output_reg), $past(tape_drive_reg), 1'b0))
    else $error("drive select pins wrong");
  a_motor_map: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) && !$past(soft_reset_req) |-> phys_motor_on_pin ==
      exp_pins($past(digital_output_reg), $past(tape_drive_reg), 1'b1))
    else $error("motor pins wrong");
endmodule // fpwdm_chk

bind fpwdm_top fpwdm_chk fpwdm_chk_i (.*);

// ==== tb/fpwdm_host.sv ====
// Host software model that issues register strobes and oscillator control.
`timescale 1ns/1ps

module fpwdm_host #(
  parameter OSC_SETTLE = 20
) (
  input  wire       clock,
  output reg        msr_read_stb,
  output reg        fifo_write_stb,
  output reg  [7:0] fifo_wdata,
  output reg        dor_write_stb,
  output reg  [7:0] dor_wdata,
  output reg        tdr_write_stb,
  output reg  [7:0] tdr_wdata,
  output reg        osc_powerdown_sw
);
  // All strobes idle at time zero.
  initial begin
    {msr_read_stb, fifo_write_stb, dor_write_stb, tdr_write_stb} = 4'h0;
    {fifo_wdata, dor_wdata, tdr_wdata} = 24'h5a5a5a;
    osc_powerdown_sw = 1'b0;
  end

  // Each strobe stands for exactly one cycle.
  task rd_msr;
    begin
      @(posedge clock);
      msr_read_stb <= 1'b1;
      @(posedge clock);
      msr_read_stb <= 1'b0;
    end
  endtask

  task wr_cmd(input [7:0] b, input pre_read);
    begin
      if (pre_read) begin
        rd_msr;
      end
      @(posedge clock);
      fifo_write_stb <= 1'b1;
      fifo_wdata <= b;
      @(posedge clock);
      fifo_write_stb <= 1'b0;
      fifo_wdata <= ~b;
    end
  endtask

  task wr_dor(input [7:0] d);
    begin
      @(posedge clock);
      dor_write_stb <= 1'b1;
      dor_wdata <= d;
      @(posedge clock);
      dor_write_stb <= 1'b0;
      dor_wdata <= ~d;
    end
  endtask

  task wr_tdr(input [7:0] d);
    begin
      @(posedge clock);
      tdr_write_stb <= 1'b1;
      tdr_wdata <= d;
      @(posedge clock);
      tdr_write_stb <= 1'b0;
      tdr_wdata <= ~d;
    end
  endtask

  // Restarting the oscillator waits out its settling time before anything else.
  task osc_set(input off);
    begin
      @(posedge clock);
      osc_powerdown_sw <= off;
      if (!off) begin
        repeat (OSC_SETTLE) @(posedge clock);
      end
    end
  endtask
endmodule // fpwdm_host

// ==== tb/fpwdm_top_bench.sv ====
// Self-checking bench for the power, wake and drive-map block.
`timescale 1ns/1ps

module fpwdm_top_bench;
  reg        clock, sys_rst, soft_reset_req, dsr_powerdown_req, auto_pd_en, core_idle;
  reg        enhanced_mode, idle_pin_mask, powerdown_pin;
  reg  [7:0] core_msr, d;
  wire       msr_read_stb, fifo_write_stb, dor_write_stb, tdr_write_stb, osc_powerdown_sw;
  wire [7:0] fifo_wdata, dor_wdata, tdr_wdata, main_status_reg, digital_output_reg;
  wire [7:0] tape_drive_reg, cmd_byte;
  wire       cmd_valid, core_init, int_req, part_awake, idle_pin, osc_powerdown, tape_mode;
  wire [1:0] status_reg_b_pd_idle, dir_pd_idle;
  wire [3:0] phys_drive_sel_pin, phys_motor_on_pin;
  integer    n_fail, checked, i, j;

  fpwdm_top #(.WAKE_CYCLES(4), .MIN_ON_CYCLES(10), .INIT_CYCLES(5)) fpwdm_top_i (.*);
  fpwdm_host fpwdm_host_i (.*);

  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Pins expected from the output and tape register values.
  function [3:0] exp_pins(input [7:0] out_reg, input [7:0] tape_reg, input motor);
    reg [3:0] v;
    begin
      v = motor ? out_reg[7:4] : 4'h1 << out_reg[1:0];
      exp_pins = v;
      if (tape_reg[3:2] == 2'h1) begin
        {exp_pins[0], exp_pins[1]} = {v[1], v[0]};
      end else if (tape_reg[3:2] == 2'h2) begin
        {exp_pins[0], exp_pins[2]} = {v[2], v[0]};
      end
    end
  endfunction

  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task step(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask

  // Waits for awake (0), interrupt (1) or command (2) to reach a level.
  task waitf(input integer sel, input v);
    integer k;
    begin
      k = 0;
      #1;
      while (k < 200 && (sel == 0 ? part_awake : sel == 1 ? int_req : cmd_valid) !== v) begin
        step(1);
        k = k + 1;
      end
      chk("wait", {7'h0, k < 200}, 8'h01);
    end
  endtask

  task t_map;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        for (j = 0; j < 4; j = j + 1) begin
          d = {4'h1 << j[1:0], 2'h0, j[1:0]};
          fpwdm_host_i.wr_tdr({4'h0, i[1:0], 2'h0});
          fpwdm_host_i.wr_dor(d);
          step(2);
          chk("sel", {4'h0, phys_drive_sel_pin}, {4'h0, exp_pins(d, {4'h0, i[1:0], 2'h0}, 1'b0)});
          chk("motor", {4'h0, phys_motor_on_pin}, {4'h0, exp_pins(d, {4'h0, i[1:0], 2'h0}, 1'b1)});
        end
      end
      fpwdm_host_i.wr_tdr(8'h0a);
      fpwdm_host_i.wr_dor(8'h02);
      step(2);
      chk("tape", {7'h0, tape_mode}, 8'h01);
      fpwdm_host_i.wr_dor(8'h00);
      step(2);
      chk("tape", {7'h0, tape_mode}, 8'h00);
    end
  endtask

  task t_auto;
    begin
      // A busy core keeps the part awake and its idle indications low.
      @(posedge clock);
      core_idle <= 1'b0;
      auto_pd_en <= 1'b1;
      step(3);
      chk("srb", {6'h0, status_reg_b_pd_idle}, 8'h00);
      chk("idle", {7'h0, idle_pin}, 8'h00);
      core_idle <= 1'b1;
      waitf(0, 1'b0);
      step(1);
      chk("status", main_status_reg, 8'h80);
      chk("srb", {6'h0, status_reg_b_pd_idle}, 8'h03);
      chk("idle", {7'h0, idle_pin}, 8'h01);
      enhanced_mode <= 1'b0;
      idle_pin_mask <= 1'b1;
      step(3);
      chk("dir", {6'h0, dir_pd_idle}, 8'h03);
      chk("idle", {7'h0, idle_pin}, 8'h00);
      idle_pin_mask <= 1'b0;
      fpwdm_host_i.rd_msr;
      step(1);
      chk("status", main_status_reg, 8'h80);
      fpwdm_host_i.wr_cmd(8'h5a, 1'b0);
      step(1);
      chk("status", main_status_reg, 8'h00);
      waitf(2, 1'b1);
      chk("cmd", cmd_byte, 8'h5a);
      waitf(0, 1'b0);
      fpwdm_host_i.rd_msr;
      waitf(0, 1'b1);
      waitf(0, 1'b0);
      fpwdm_host_i.wr_cmd(8'h3c, 1'b0);
      step(1);
      chk("status", main_status_reg, 8'h00);
      waitf(2, 1'b1);
      chk("cmd", cmd_byte, 8'h3c);
      waitf(0, 1'b0);
      fpwdm_host_i.wr_dor(8'h10);
      step(1);
      chk("status", main_status_reg, 8'h80);
      waitf(0, 1'b1);
      auto_pd_en <= 1'b0;
      fpwdm_host_i.wr_dor(8'h01);
    end
  endtask

  task t_dsr;
    begin
      // Let the minimum on time run out so the part is fully awake first.
      step(20);
      core_msr <= 8'h91;
      step(2);
      chk("status", main_status_reg, 8'h91);
      fpwdm_host_i.wr_cmd(8'hc3, 1'b1);
      waitf(2, 1'b1);
      chk("cmd", cmd_byte, 8'hc3);
      for (i = 0; i < 2; i = i + 1) begin
        fpwdm_host_i.wr_dor(8'h01);
        @(posedge clock);
        dsr_powerdown_req <= 1'b1;
        @(posedge clock);
        dsr_powerdown_req <= 1'b0;
        fpwdm_host_i.wr_dor(8'h32);
        step(2);
        chk("status", main_status_reg, 8'h80);
        chk("out reg", digital_output_reg, 8'h01);
        @(posedge clock);
        soft_reset_req <= (i == 0);
        sys_rst <= (i == 1);
        @(posedge clock);
        soft_reset_req <= 1'b0;
        sys_rst <= 1'b0;
        #1;
        chk("init", {7'h0, core_init}, 8'h01);
        chk("out reg", digital_output_reg, 8'h00);
        waitf(1, 1'b1);
      end
    end
  endtask

  task t_osc;
    begin
      powerdown_pin <= 1'b1;
      step(6);
      chk("osc", {7'h0, osc_powerdown}, 8'h01);
      powerdown_pin <= 1'b0;
      fpwdm_host_i.osc_set(1'b1);
      step(6);
      chk("osc", {7'h0, osc_powerdown}, 8'h01);
      fpwdm_host_i.osc_set(1'b0);
      step(1);
      chk("osc", {7'h0, osc_powerdown}, 8'h00);
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail = n_fail + 1;
    results;
  end

  // Main sequence.
  initial begin
    {sys_rst, core_idle, enhanced_mode} = 3'h7;
    {soft_reset_req, dsr_powerdown_req, auto_pd_en, idle_pin_mask, powerdown_pin} = 5'h0;
    core_msr = 8'h90;
    n_fail = 0;
    checked = 0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    waitf(1, 1'b1);
    chk("out reg", digital_output_reg, 8'h00);
    chk("tape reg", tape_drive_reg, 8'h00);
    t_map;
    t_auto;
    t_dsr;
    t_osc;
    results;
  end
endmodule // fpwdm_top_bench
